// *** hdl/alsc_regs.vh ***
// Constants for the accumulator logic, shift and convert unit
// Assumes inclusion by the single design module of the unit
`ifndef ALSC_REGS_VH
`define ALSC_REGS_VH

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define ALSC_OP_W          4
`define ALSC_OP_NOP        4'h0
`define ALSC_OP_OR         4'h1
`define ALSC_OP_SHR        4'h2
`define ALSC_OP_SHL        4'h3
`define ALSC_OP_DECODE     4'h4
`define ALSC_OP_ENCODE     4'h5
`define ALSC_OP_COMPLEMENT 4'h6
`define ALSC_OP_DEC2BIN    4'h7
`define ALSC_OP_BIN2DEC    4'h8
`define ALSC_OP_FAULT      4'h9
`define ALSC_OP_LOAD       4'ha

// ----------------------------------------------------------------
// Data layout and limits
// ----------------------------------------------------------------
`define ALSC_ACC_W         16
`define ALSC_CNT_W         4
`define ALSC_ACC_RST       16'h0000
`define ALSC_FAULT_RST     16'h0000
`define ALSC_BCD_MAX       17'h0270f
`define ALSC_POS_W         4
`define ALSC_FLAG_RST      1'b0
`define ALSC_FLO_LSB       0
`define ALSC_FLO_MSB       7
`define ALSC_FHI_LSB       8
`define ALSC_FHI_MSB       15

`endif

// *** hdl/alsc_unit.v ***
// Accumulator datapath: OR, shifts, decode/encode, complement,
// BCD/binary conversion and fault-number capture with flag coils.
// Assumes a sequencer on MCLK issuing one operation per enabled cycle.
//
// Functional notes
// - OR operand into accumulator, store result, zero flag if all zero.
// - Shift right by count, zeros enter at the top.
// - Shift left by count, zeros enter at the bottom.
// - Carry flag set if any one bit leaves during a shift.
// - Zero flag set after a shift leaving all bits zero.
// - Decode uses only low four bits as a position 0 to 15.
// - Encode turns set bit position into a 4-bit number, low bits.
// - Encode clears the twelve upper accumulator bits.
// - Complement inverts all sixteen accumulator bits.
// - Four BCD digits converted to the unsigned binary value.
// - Binary converted to four BCD digits, overflow above 9999.
// - Fault operation captures its BCD number into two data registers.
// - Later fault operations overwrite earlier fault numbers.
`timescale 1ns/1ps
`include "alsc_regs.vh"

module alsc_unit #(
  parameter ACC_W = `ALSC_ACC_W
) (
  // Clock, reset, enable
  input  wire             MCLK,
  input  wire             RST_B,
  input  wire             CE,
  // Operation request
  input  wire             OP_EN,
  input  wire [3:0]       OP_CODE,
  input  wire [ACC_W-1:0] OPERAND,
  input  wire [3:0]       SHIFT_CNT,
  // Accumulator and flags
  output wire [ACC_W-1:0] ACC,
  output wire             CARRY_FLAG,
  output wire             ZERO_FLAG,
  output wire             OVERFLOW_FLAG,
  // Fault number data registers
  output wire [7:0]       FAULT_LO,
  output wire [7:0]       FAULT_HI,
  output wire             FAULT_VALID
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function [3:0] enc_highest;
    input [15:0] v;
    integer i;
    begin
      enc_highest = 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        if (v[i]) begin
          enc_highest = i[3:0];
        end
      end
    end
  endfunction

  function [15:0] bcd_to_bin;
    input [15:0] d;
    begin
      bcd_to_bin = {12'h000, d[3:0]}
                 + ({12'h000, d[7:4]} * 16'd10)
                 + ({12'h000, d[11:8]} * 16'd100)
                 + ({12'h000, d[15:12]} * 16'd1000);
    end
  endfunction

  // Double-dabble; only four digits kept, overflow reported apart
  function [15:0] bin_to_bcd;
    input [15:0] b;
    integer i;
    reg [35:0] s;
    begin
      s = {20'h00000, b};
      for (i = 0; i < 16; i = i + 1) begin
        if (s[19:16] > 4'h4) s[19:16] = s[19:16] + 4'h3;
        if (s[23:20] > 4'h4) s[23:20] = s[23:20] + 4'h3;
        if (s[27:24] > 4'h4) s[27:24] = s[27:24] + 4'h3;
        if (s[31:28] > 4'h4) s[31:28] = s[31:28] + 4'h3;
        s = {s[34:0], 1'b0};
      end
      bin_to_bcd = s[31:16];
    end
  endfunction

  // Shift ops are decoded in more than one place
  function is_shift;
    input [`ALSC_OP_W-1:0] op;
    begin
      is_shift = (op == `ALSC_OP_SHR) || (op == `ALSC_OP_SHL);
    end
  endfunction

  function sets_zero;
    input [`ALSC_OP_W-1:0] op;
    begin
      sets_zero = is_shift(op) || (op == `ALSC_OP_OR);
    end
  endfunction

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  wire             op_take;
  wire             op_shift;
  wire             op_zero;
  wire             op_ovf;

  // A held strobe repeats the op on every enabled edge
  assign op_take  = CE & OP_EN;
  assign op_shift = is_shift(OP_CODE);
  assign op_zero  = sets_zero(OP_CODE);
  assign op_ovf   = (OP_CODE == `ALSC_OP_BIN2DEC);

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  reg  [ACC_W-1:0] acc_r;
  reg              carry_r;
  reg              zero_r;
  reg              ovf_r;
  reg  [7:0]       fault_lo_r;
  reg  [7:0]       fault_hi_r;
  reg              fault_valid_r;

  // ----------------------------------------------------------------
  // Logic results
  // ----------------------------------------------------------------
  wire [ACC_W-1:0]   or_res;
  wire [ACC_W-1:0]   dec_res;
  wire [ACC_W-1:0]   enc_res;
  wire [ACC_W-1:0]   cpl_res;
  genvar             g;

  assign or_res  = acc_r | OPERAND;
  assign cpl_res = ~acc_r;
  assign enc_res = {{(ACC_W-`ALSC_POS_W){1'b0}},
                    enc_highest(acc_r)};

  // Upper bits of the source play no part in the position
  generate
    for (g = 0; g < ACC_W; g = g + 1) begin : g_dec
      assign dec_res[g] = (acc_r[`ALSC_POS_W-1:0] == g);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shift results
  // ----------------------------------------------------------------
  wire [2*ACC_W-1:0] shr_w;
  wire [2*ACC_W-1:0] shl_w;
  wire [ACC_W-1:0]   shr_res;
  wire [ACC_W-1:0]   shl_res;
  wire               shr_cy;
  wire               shl_cy;

  // Double-width shift: the spill half holds every bit pushed out.
  // Counts span 0..15 from the 4-bit field; a zero count just passes through
  assign shr_w   = {acc_r, {ACC_W{1'b0}}} >> SHIFT_CNT;
  assign shl_w   = {{ACC_W{1'b0}}, acc_r} << SHIFT_CNT;
  assign shr_res = shr_w[2*ACC_W-1:ACC_W];
  assign shl_res = shl_w[ACC_W-1:0];
  assign shr_cy  = |shr_w[ACC_W-1:0];
  assign shl_cy  = |shl_w[2*ACC_W-1:ACC_W];

  // ----------------------------------------------------------------
  // Code conversion results
  // ----------------------------------------------------------------
  wire [ACC_W-1:0]   d2b_res;
  wire [ACC_W-1:0]   b2d_res;
  wire               b2d_ovf;

  // Invalid BCD digits still give their weighted sum, no error flag
  assign d2b_res = bcd_to_bin(acc_r);
  // Above the limit only the low four digits survive
  assign b2d_res = bin_to_bcd(acc_r);
  assign b2d_ovf = ({1'b0, acc_r} > `ALSC_BCD_MAX);

  // ----------------------------------------------------------------
  // Next-state datapath
  // ----------------------------------------------------------------
  reg  [ACC_W-1:0] acc_nxt;
  reg              fault_we;

  always @* begin
    acc_nxt  = acc_r;
    fault_we = 1'b0;
    case (OP_CODE)
      `ALSC_OP_OR: begin
        acc_nxt = or_res;
      end

      `ALSC_OP_SHR: begin
        acc_nxt = shr_res;
      end

      `ALSC_OP_SHL: begin
        acc_nxt = shl_res;
      end

      `ALSC_OP_DECODE: begin
        acc_nxt = dec_res;
      end

      `ALSC_OP_ENCODE: begin
        acc_nxt = enc_res;
      end

      `ALSC_OP_COMPLEMENT: begin
        acc_nxt = cpl_res;
      end

      `ALSC_OP_DEC2BIN: begin
        acc_nxt = d2b_res;
      end

      `ALSC_OP_BIN2DEC: begin
        acc_nxt = b2d_res;
      end

      `ALSC_OP_FAULT: begin
        fault_we = 1'b1;
      end

      `ALSC_OP_LOAD: begin
        acc_nxt = OPERAND;
      end

      default: begin
        acc_nxt = acc_r;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Flag next values
  // ----------------------------------------------------------------
  reg              carry_nxt;
  reg              zero_nxt;
  reg              ovf_nxt;

  // Flags move only for the ops that own them; others stay sticky
  always @* begin
    carry_nxt = carry_r;
    zero_nxt  = zero_r;
    ovf_nxt   = ovf_r;
    if (op_shift) begin
      carry_nxt = (OP_CODE == `ALSC_OP_SHL) ? shl_cy : shr_cy;
    end
    if (op_zero) begin
      zero_nxt = ~|acc_nxt;
    end
    if (op_ovf) begin
      ovf_nxt = b2d_ovf;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and flag coils
  // ----------------------------------------------------------------
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      acc_r   <= `ALSC_ACC_RST;
      carry_r <= `ALSC_FLAG_RST;
      zero_r  <= `ALSC_FLAG_RST;
      ovf_r   <= `ALSC_FLAG_RST;
    end else if (op_take) begin
      acc_r   <= acc_nxt;
      carry_r <= carry_nxt;
      zero_r  <= zero_nxt;
      ovf_r   <= ovf_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fault number registers
  // ----------------------------------------------------------------
  // Last capture wins: no priority among faults in a scan
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      {fault_hi_r, fault_lo_r} <= `ALSC_FAULT_RST;
      fault_valid_r            <= `ALSC_FLAG_RST;
    end else if (op_take && fault_we) begin
      fault_lo_r    <= OPERAND[`ALSC_FLO_MSB:`ALSC_FLO_LSB];
      fault_hi_r    <= OPERAND[`ALSC_FHI_MSB:`ALSC_FHI_LSB];
      fault_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ACC           = acc_r;
  assign CARRY_FLAG    = carry_r;
  assign ZERO_FLAG     = zero_r;
  assign OVERFLOW_FLAG = ovf_r;
  assign FAULT_LO      = fault_lo_r;
  assign FAULT_HI      = fault_hi_r;
  assign FAULT_VALID   = fault_valid_r;

endmodule

// *** verification/alsc_monitor.sv ***
// Checker on the ports of the accumulator unit
// Assumes one clock, async active-low reset
`timescale 1ns/1ps
module alsc_monitor #(parameter ACC_W = 16) (
  // Clock, reset, request
  input wire             MCLK,
  input wire             RST_B,
  input wire             CE,
  input wire             OP_EN,
  input wire [3:0]       OP_CODE,
  input wire [ACC_W-1:0] OPERAND,
  input wire [3:0]       SHIFT_CNT,
  // Results
  input wire [ACC_W-1:0] ACC,
  input wire             CARRY_FLAG,
  input wire             ZERO_FLAG,
  input wire             OVERFLOW_FLAG,
  input wire [7:0]       FAULT_LO,
  input wire [7:0]       FAULT_HI,
  input wire             FAULT_VALID
);
  // ----
  // Properties
  // ----
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  wire        t  = CE & OP_EN;
  wire        sh = t & (OP_CODE == 4'h2 | OP_CODE == 4'h3);
  // Bits that leave the accumulator for this count
  wire [15:0] mk = OP_CODE == 4'h3 ? ~(16'hffff >> SHIFT_CNT)
                                   : (16'h1 << SHIFT_CNT) - 16'h1;
  chk_or_result:
    assert property (t && OP_CODE == 4'h1 |=> ACC == ($past(ACC) |
      $past(OPERAND)) && ZERO_FLAG == (ACC == 0)) else $error("or");
  chk_shift_right:
    assert property (t && OP_CODE == 4'h2 |=>
      ACC == $past(ACC) >> $past(SHIFT_CNT)) else $error("shr");
  chk_shift_left:
    assert property (t && OP_CODE == 4'h3 |=>
      ACC == $past(ACC) << $past(SHIFT_CNT)) else $error("shl");
  chk_carry_out:
    assert property (sh |=> CARRY_FLAG == |($past(ACC) & $past(mk)))
      else $error("carry");
  chk_shift_zero:
    assert property (sh |=> ZERO_FLAG == (ACC == 0)) else $error("zero");
  chk_decode_hot:
    assert property (t && OP_CODE == 4'h4 |=>
      ACC == 16'h1 << $past(ACC[3:0])) else $error("decode");
  chk_encode_top:
    assert property (t && OP_CODE == 4'h5 |=> ACC[15:4] == 0 &&
      ($past(ACC) >> ACC[3:0]) == ($past(ACC) != 0)) else $error("enc");
  chk_invert_all:
    assert property (t && OP_CODE == 4'h6 |=> ACC == ~$past(ACC))
      else $error("invert");
  chk_bcd_ovf:
    assert property (t && OP_CODE == 4'h8 |=>
      OVERFLOW_FLAG == ($past(ACC) > 9999)) else $error("ovf");
  chk_fault_num:
    assert property (t && OP_CODE == 4'h9 |=> FAULT_VALID &&
      {FAULT_HI, FAULT_LO} == $past(OPERAND)) else $error("fault");
endmodule
bind alsc_unit alsc_monitor #(.ACC_W(ACC_W)) mon (.*);

// *** verification/alsc_seq.sv ***
// Sequencer model issuing one operation per call
// Assumes the unit takes ops on the rising clock edge
`timescale 1ns/1ps
module alsc_seq (
  // Clock and request
  input wire        MCLK,
  output reg        OP_EN = 1'b0,
  output reg [3:0]  OP_CODE = 4'h0,
  output reg [15:0] OPERAND = 16'h0,
  output reg [3:0]  SHIFT_CNT = 4'h1
);
  task issue(input [3:0] c, input [15:0] d, input [3:0] n);
    @(posedge MCLK);
    #1 {OP_EN, OP_CODE, OPERAND, SHIFT_CNT} = {1'b1, c, d, n};
    @(posedge MCLK);
    #1 OP_EN = 1'b0;
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the accumulator unit
// Assumes the sequencer model drives every operation
`timescale 1ns/1ps
module tb;
  reg         MCLK = 1'b0;
  reg         RST_B = 1'b0;
  reg         ce = 1'b1;
  wire        op_en, cy, zf, of, fv;
  wire [3:0]  opc, cnt;
  wire [15:0] opd, acc;
  wire [7:0]  flo, fhi;
  integer     n_errors = 0;
  integer     checks = 0;
  alsc_unit dut (.MCLK(MCLK), .RST_B(RST_B), .CE(ce), .OP_EN(op_en),
    .OP_CODE(opc), .OPERAND(opd), .SHIFT_CNT(cnt), .ACC(acc),
    .CARRY_FLAG(cy), .ZERO_FLAG(zf), .OVERFLOW_FLAG(of),
    .FAULT_LO(flo), .FAULT_HI(fhi), .FAULT_VALID(fv));
  alsc_seq seq (.MCLK(MCLK), .OP_EN(op_en), .OP_CODE(opc),
    .OPERAND(opd), .SHIFT_CNT(cnt));
  initial forever #4 MCLK = ~MCLK;
  task chk(input [17:0] g, input [17:0] e);
    checks = checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task op(input [3:0] c, input [15:0] d, input [3:0] n);
    seq.issue(c, d, n);
  endtask
  // ----
  // Scenarios
  // ----
  task t_or;
    op(4'ha, 16'h3210, 4'h1); op(4'h1, 16'h7531, 4'h1);
    chk({zf, acc}, {1'b0, 16'h7731});
    op(4'ha, 16'h0, 4'h1); op(4'h1, 16'h0, 4'h1);
    chk({zf, acc}, {1'b1, 16'h0});
  endtask
  task t_shift;
    op(4'ha, 16'h00ff, 4'h1); op(4'h2, 16'h0, 4'h6);
    chk({zf, cy, acc}, {2'b01, 16'h0003});
    op(4'ha, 16'h5362, 4'h1); op(4'h3, 16'h0, 4'h4);
    chk({zf, cy, acc}, {2'b01, 16'h3620});
    op(4'h2, 16'h0, 4'h4);
    chk({zf, cy, acc}, {2'b00, 16'h0362});
    op(4'ha, 16'h8000, 4'h1); op(4'h3, 16'h0, 4'hf);
    chk({zf, cy, acc}, {2'b11, 16'h0});
  endtask
  task t_code;
    op(4'ha, 16'hfff6, 4'h1); op(4'h4, 16'h0, 4'h1);
    chk(acc, 16'h0040);
    op(4'ha, 16'h8140, 4'h1); op(4'h5, 16'h0, 4'h1);
    chk(acc, 16'h000f);
    op(4'ha, 16'h0, 4'h1); op(4'h5, 16'h0, 4'h1);
    chk(acc, 16'h0);
    op(4'h6, 16'h0, 4'h1); chk(acc, 16'hffff);
  endtask
  task t_conv;
    op(4'ha, 16'h1234, 4'h1); op(4'h7, 16'h0, 4'h1);
    chk(acc, 16'h04d2);
    op(4'h8, 16'h0, 4'h1); chk({of, acc}, {1'b0, 16'h1234});
    op(4'ha, 16'h2710, 4'h1); op(4'h8, 16'h0, 4'h1);
    chk({of, acc}, {1'b1, 16'h0});
  endtask
  task t_fault;
    op(4'h9, 16'h1111, 4'h1);
    chk({fv, fhi, flo}, {1'b1, 16'h1111});
    op(4'h9, 16'h2222, 4'h1);
    chk({fv, fhi, flo}, {1'b1, 16'h2222});
  endtask
  task t_hold;
    op(4'ha, 16'h0f0f, 4'h1);
    ce = 1'b0;
    op(4'h6, 16'h0, 4'h1);
    chk(acc, 16'h0f0f);
    ce = 1'b1;
    op(4'hb, 16'h0, 4'h1);
    chk(acc, 16'h0f0f);
    op(4'h6, 16'h0, 4'h1);
    chk(acc, 16'hf0f0);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge MCLK);
    #1 RST_B = 1'b1;
    t_or; t_shift; t_code; t_conv; t_fault; t_hold;
    print_verdict;
  end
endmodule
